// ===== arpcc_dev.sv
// Purpose: converter-side control of reference source, power scaling, sleep and conversion
// Assumes: link pins come from another party and are synchronised here
// Notes: analog enables are level outputs to the analog macro
//
// Summary of operation
// - both reference pins low: bandgap, buffer, sensor on
// - internal ref off, buffer input pin buffered
// - both pins high: reference and buffer off
// - sensor enabled only with internal reference
// - impulse mode: low current after conversion ends
// - digital interface stays active during acquisition
// - sleep pin high enters minimum-current state
// - finish conversion first; bus stays active asleep
// - configuration bit may also request sleep
// - configuration control ignores sleep pin; pin tied
// - falling convert-start edge begins a conversion
// - running conversion ignores starts, defers sleep
// - start independent of chip-select and read-enable

`timescale 1ns/1ps

// ********************************************************************
// module
// ********************************************************************
module arpcc_dev
    import arpcc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    arpcc_link_if.dev LINK,
    input wire logic IMPULSE_MODE_IN,
    output logic BANDGAP_EN_OUT,
    output logic REFBUF_EN_OUT,
    output logic BUF_FROM_PIN_OUT,
    output logic TEMP_EN_OUT,
    output logic LOW_CURRENT_OUT,
    output logic SLEEP_OUT,
    output logic BUSY_OUT,
    output logic DATA_OE_OUT,
    output logic DIGITAL_ACTIVE_OUT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [SY_W-1:0] pin_vec;
    logic [SY_W-1:0] meta_r;
    logic [SY_W-1:0] sync_r;
    logic start_d_r;
    arpcc_dev_state_t state_r;
    arpcc_dev_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic iref_pd;
    logic buf_pd;
    logic start_n;
    logic start_edge;
    logic sleep_req;
    logic conv_end;
    logic asleep_nxt;
    logic bandgap_nxt;
    logic refbuf_nxt;
    logic buf_pin_nxt;
    logic temp_nxt;
    logic low_cur_nxt;
    logic busy_nxt;
    logic oe_nxt;
    logic bandgap_r;
    logic refbuf_r;
    logic buf_pin_r;
    logic temp_r;
    logic low_cur_r;
    logic sleep_r;
    logic busy_r;
    logic oe_r;
    logic active_r;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    assign pin_vec[SY_IREF_PD] = LINK.internal_ref_powerdown;
    assign pin_vec[SY_BUF_PD] = LINK.ref_buffer_powerdown;
    assign pin_vec[SY_SLEEP] = LINK.sleep_request;
    assign pin_vec[SY_START_N] = LINK.convert_start_n;
    assign pin_vec[SY_CS_N] = LINK.cs_n;
    assign pin_vec[SY_RD_N] = LINK.rd_n;
    assign pin_vec[SY_CFG_CTRL] = LINK.cfg_sleep_ctrl;
    assign pin_vec[SY_CFG_SLEEP] = LINK.cfg_sleep;

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            meta_r <= SY_RST;
            sync_r <= SY_RST;
            start_d_r <= 1'b1;
        end
        else if (CE_IN)
        begin
            meta_r <= pin_vec;
            sync_r <= meta_r;
            start_d_r <= sync_r[SY_START_N];
        end
    end

    // ****************************************************************
    // decoding
    // ****************************************************************
    assign iref_pd = sync_r[SY_IREF_PD];
    assign buf_pd = sync_r[SY_BUF_PD];
    assign start_n = sync_r[SY_START_N];

    // edge taken from the start pin alone, chip-select and read-enable play no part
    assign start_edge = start_d_r & ~start_n;

    // configuration control selects the bit and leaves the pin unread
    assign sleep_req = sync_r[SY_CFG_CTRL] ? sync_r[SY_CFG_SLEEP] : sync_r[SY_SLEEP];

    assign conv_end = (state_r == DEV_CONV) && (cnt_r == CONV_LAST);

    // ****************************************************************
    // conversion and sleep sequencer
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            DEV_ACQ:
            begin
                if (start_edge)
                begin
                    state_nxt = DEV_CONV;
                    cnt_nxt = CNT_ZERO;
                end
                else if (sleep_req)
                begin
                    state_nxt = DEV_SLEEP;
                end
            end
            DEV_CONV:
            begin
                // further edges are dropped, sleep requests wait for the end
                if (conv_end)
                begin
                    state_nxt = sleep_req ? DEV_SLEEP : DEV_ACQ;
                    cnt_nxt = CNT_ZERO;
                end
                else
                begin
                    cnt_nxt = cnt_r + 9'h001;
                end
            end
            DEV_SLEEP:
            begin
                if (!sleep_req)
                begin
                    state_nxt = DEV_ACQ;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            state_r <= DEV_ACQ;
            cnt_r <= CNT_ZERO;
        end
        else if (CE_IN)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************************************
    // reference selection
    // ****************************************************************
    assign asleep_nxt = (state_nxt == DEV_SLEEP);
    assign bandgap_nxt = ~iref_pd & ~asleep_nxt;
    assign refbuf_nxt = ~buf_pd & ~asleep_nxt;
    assign buf_pin_nxt = iref_pd & ~buf_pd & ~asleep_nxt;
    assign temp_nxt = ~iref_pd & ~buf_pd & ~asleep_nxt;

    // ****************************************************************
    // power scaling, busy and bus enable
    // ****************************************************************
    // low from each conversion end through the acquisition, raised again by a start
    always_comb
    begin
        low_cur_nxt = low_cur_r;
        if (!IMPULSE_MODE_IN)
        begin
            low_cur_nxt = 1'b0;
        end
        else if (conv_end)
        begin
            low_cur_nxt = 1'b1;
        end
        else if (state_nxt == DEV_CONV)
        begin
            low_cur_nxt = 1'b0;
        end
    end

    assign busy_nxt = (state_nxt == DEV_CONV);
    // bus enable never gated by sleep or power scaling
    assign oe_nxt = ~sync_r[SY_CS_N] & ~sync_r[SY_RD_N];

    // ****************************************************************
    // output registers
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            bandgap_r <= 1'b0;
            refbuf_r <= 1'b0;
            buf_pin_r <= 1'b0;
            temp_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            bandgap_r <= bandgap_nxt;
            refbuf_r <= refbuf_nxt;
            buf_pin_r <= buf_pin_nxt;
            temp_r <= temp_nxt;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            low_cur_r <= 1'b0;
            sleep_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            low_cur_r <= low_cur_nxt;
            sleep_r <= asleep_nxt;
            busy_r <= busy_nxt;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            oe_r <= 1'b0;
            active_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            oe_r <= oe_nxt;
            active_r <= 1'b1;
        end
    end

    // ****************************************************************
    // port drive
    // ****************************************************************
    assign BANDGAP_EN_OUT = bandgap_r;
    assign REFBUF_EN_OUT = refbuf_r;
    assign BUF_FROM_PIN_OUT = buf_pin_r;
    assign TEMP_EN_OUT = temp_r;
    assign LOW_CURRENT_OUT = low_cur_r;
    assign SLEEP_OUT = sleep_r;
    assign BUSY_OUT = busy_r;
    assign DATA_OE_OUT = oe_r;
    assign DIGITAL_ACTIVE_OUT = active_r;
    assign LINK.busy = busy_r;

endmodule : arpcc_dev

// ===== arpcc_pkg.sv
// Purpose: shared constants and types for the reference, power and conversion control ends
// Assumes: one 250 MHz clock on both ends
// Notes: link pins are plain levels; the host end exposes them through APB registers

// ********************************************************************
// package
// ********************************************************************
package arpcc_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4;
    // conversion phase length
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least low and high time of the convert-start pulse
    localparam int START_PULSE_NS = 20;
    localparam int START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(START_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;

    // ****************************************************************
    // synchronised link input vector of the device end
    // ****************************************************************
    localparam int SY_W = 8;
    localparam int SY_IREF_PD = 7;
    localparam int SY_BUF_PD = 6;
    localparam int SY_SLEEP = 5;
    localparam int SY_START_N = 4;
    localparam int SY_CS_N = 3;
    localparam int SY_RD_N = 2;
    localparam int SY_CFG_CTRL = 1;
    localparam int SY_CFG_SLEEP = 0;
    localparam logic [SY_W-1:0] SY_RST = 8'h1C;

    // ****************************************************************
    // host register map (byte addresses)
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
    // control register fields
    localparam int CT_IREF_PD = 0;
    localparam int CT_BUF_PD = 1;
    localparam int CT_SLEEP = 2;
    localparam int CT_CFG_CTRL = 3;
    localparam int CT_CFG_SLEEP = 4;
    localparam int CT_CS_N = 5;
    localparam int CT_RD_N = 6;
    localparam int CT_W = 7;
    localparam logic [CT_W-1:0] CTRL_RST = 7'h60;
    // command register field
    localparam int CM_START = 0;
    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_PULSE = 1;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef enum logic [1:0] {DEV_ACQ, DEV_CONV, DEV_SLEEP} arpcc_dev_state_t;
    typedef enum logic [1:0] {HST_IDLE, HST_LOW, HST_HIGH} arpcc_hst_state_t;

endpackage : arpcc_pkg

// ===== arpcc_link_if.sv
// Purpose: pin-level link between the host controller and the converter control
// Assumes: both ends on the same board clock, device synchronises every pin
// Notes: all signals are plain one-way levels

`timescale 1ns/1ps

// ********************************************************************
// interface
// ********************************************************************
interface arpcc_link_if;
    logic internal_ref_powerdown;
    logic ref_buffer_powerdown;
    logic sleep_request;
    logic convert_start_n;
    logic cs_n;
    logic rd_n;
    logic cfg_sleep_ctrl;
    logic cfg_sleep;
    logic busy;

    modport dev (
        input internal_ref_powerdown,
        input ref_buffer_powerdown,
        input sleep_request,
        input convert_start_n,
        input cs_n,
        input rd_n,
        input cfg_sleep_ctrl,
        input cfg_sleep,
        output busy
    );

    modport hst (
        output internal_ref_powerdown,
        output ref_buffer_powerdown,
        output sleep_request,
        output convert_start_n,
        output cs_n,
        output rd_n,
        output cfg_sleep_ctrl,
        output cfg_sleep,
        input busy
    );
endinterface : arpcc_link_if

// ===== arpcc_hst.sv
// Purpose: host-side driver of the converter control pins, steered over APB
// Assumes: zero-wait APB slave, answer one cycle after setup
// Notes: the start pulse width comes from the timing constants

`timescale 1ns/1ps

// ********************************************************************
// module
// ********************************************************************
module arpcc_hst
    import arpcc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    arpcc_link_if.hst LINK,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [CT_W-1:0] ctrl_r;
    logic [CT_W-1:0] ctrl_nxt;
    logic busy_meta_r;
    logic busy_sync_r;
    arpcc_hst_state_t state_r;
    arpcc_hst_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic start_n_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic setup;
    logic wr_take;
    logic hit_ctrl;
    logic hit_cmd;
    logic hit_stat;
    logic mapped;
    logic start_req;
    logic [31:0] rd_mux;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign setup = PSEL_IN & ~PENABLE_IN;
    assign wr_take = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN & ~pslverr_r;
    assign hit_ctrl = (PADDR_IN == OFS_CTRL);
    assign hit_cmd = (PADDR_IN == OFS_CMD);
    assign hit_stat = (PADDR_IN == OFS_STATUS);
    assign mapped = hit_ctrl | hit_cmd | hit_stat;
    assign start_req = wr_take & hit_cmd & PWDATA_IN[CM_START];
    assign rd_mux = hit_ctrl ? {25'h0, ctrl_r} :
        hit_stat ? {30'h0, (state_r != HST_IDLE), busy_sync_r} : RD_ZERO;

    // sleep pin frozen at its last level while the configuration bit rules
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_take && hit_ctrl)
        begin
            ctrl_nxt = PWDATA_IN[CT_W-1:0];
            if (ctrl_r[CT_CFG_CTRL] || PWDATA_IN[CT_CFG_CTRL])
            begin
                ctrl_nxt[CT_SLEEP] = ctrl_r[CT_SLEEP];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            prdata_r <= RD_ZERO;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= (setup & ~PWRITE_IN) ? rd_mux : RD_ZERO;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl_r <= CTRL_RST;
            busy_meta_r <= 1'b0;
            busy_sync_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            ctrl_r <= ctrl_nxt;
            busy_meta_r <= LINK.busy;
            busy_sync_r <= busy_meta_r;
        end
    end

    // ****************************************************************
    // convert-start pulse generator
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            HST_IDLE:
            begin
                if (start_req)
                begin
                    state_nxt = HST_LOW;
                    cnt_nxt = CNT_ZERO;
                end
            end
            HST_LOW, HST_HIGH:
            begin
                if (cnt_r == PULSE_LAST)
                begin
                    state_nxt = (state_r == HST_LOW) ? HST_HIGH : HST_IDLE;
                    cnt_nxt = CNT_ZERO;
                end
                else
                begin
                    cnt_nxt = cnt_r + 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            state_r <= HST_IDLE;
            cnt_r <= CNT_ZERO;
            start_n_r <= 1'b1;
        end
        else if (CE_IN)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            start_n_r <= (state_nxt != HST_LOW);
        end
    end

    // ****************************************************************
    // port drive
    // ****************************************************************
    assign LINK.internal_ref_powerdown = ctrl_r[CT_IREF_PD];
    assign LINK.ref_buffer_powerdown = ctrl_r[CT_BUF_PD];
    assign LINK.sleep_request = ctrl_r[CT_SLEEP];
    assign LINK.cfg_sleep_ctrl = ctrl_r[CT_CFG_CTRL];
    assign LINK.cfg_sleep = ctrl_r[CT_CFG_SLEEP];
    assign LINK.cs_n = ctrl_r[CT_CS_N];
    assign LINK.rd_n = ctrl_r[CT_RD_N];
    assign LINK.convert_start_n = start_n_r;
    assign PRDATA_OUT = prdata_r;
    assign PREADY_OUT = pready_r;
    assign PSLVERR_OUT = pslverr_r;

endmodule : arpcc_hst

// ===== arpcc_monitor.sv
// Purpose: concurrent checks on the link between host end and device end
// Assumes: one clock, link levels sampled on its rising edge
// Notes: instantiated beside the link interface, no bind

`timescale 1ns/1ps

// ****************************************************************
// checker
// ****************************************************************
module arpcc_monitor
    import arpcc_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic sleep_request,
    input wire logic convert_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic cfg_sleep_ctrl,
    input wire logic cfg_sleep,
    input wire logic busy
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    logic eff_sleep;
    logic [2:0] awake_r;
    logic [2:0] asleep_r;
    logic [CNT_W-1:0] busy_len_r;
    // sleep as the device should obey it, pin or configuration bit
    assign eff_sleep = cfg_sleep_ctrl ? cfg_sleep : sleep_request;

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            awake_r <= 3'h0;
            asleep_r <= 3'h0;
            busy_len_r <= 9'h000;
        end
        else
        begin
            awake_r <= eff_sleep ? 3'h0 : ((awake_r == 3'h7) ? 3'h7 : awake_r + 3'h1);
            asleep_r <= !eff_sleep ? 3'h0 : ((asleep_r == 3'h7) ? 3'h7 : asleep_r + 3'h1);
            busy_len_r <= busy ? busy_len_r + 9'h001 : 9'h000;
        end
    end

    property p_start_busy;
        $fell(convert_start_n) && !busy && awake_r == 3'h7 |-> ##3 busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy late after start");
    property p_start_free;
        $fell(convert_start_n) && !busy && awake_r == 3'h7 && !cs_n && !rd_n
            |-> ##2 !busy ##1 busy;
    endproperty
    a_start_free: assert property (p_start_free) else $error("start held by select");
    property p_busy_cause;
        $rose(busy) |-> $past(convert_start_n, 4) && !$past(convert_start_n, 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    property p_busy_width;
        $fell(busy) |-> busy_len_r == CNT_W'(CONV_CYC);
    endproperty
    a_busy_width: assert property (p_busy_width) else $error("conversion length wrong");
    property p_busy_max;
        busy_len_r <= CNT_W'(CONV_CYC);
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("conversion restarted");
    property p_asleep_idle;
        asleep_r == 3'h7 && !busy |=> !busy;
    endproperty
    a_asleep_idle: assert property (p_asleep_idle) else $error("started while asleep");
    property p_pulse_low;
        $fell(convert_start_n) |-> !convert_start_n [*5] ##1 convert_start_n;
    endproperty
    a_pulse_low: assert property (p_pulse_low) else $error("start pulse width wrong");
    property p_pulse_gap;
        $rose(convert_start_n) |-> convert_start_n [*5];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap) else $error("start pulse gap short");
    property p_pin_tied;
        cfg_sleep_ctrl && $past(cfg_sleep_ctrl) |-> $stable(sleep_request);
    endproperty
    a_pin_tied: assert property (p_pin_tied) else $error("sleep pin moved");

    c_conv: cover property ($fell(busy));
    c_start_busy: cover property (busy && $fell(convert_start_n));
    c_asleep: cover property (asleep_r == 3'h7 && !busy);
endmodule : arpcc_monitor

// ===== arpcc_test.sv
// Purpose: self-checking bench of host end and device end joined by the link
// Assumes: zero-wait APB answer, registered device outputs
// Notes: device outputs compared on falling edges

`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end

// ****************************************************************
// bench
// ****************************************************************
module arpcc_test;
    import arpcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic imp = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bg, rb, bfp, temp, lowc, slp, bsy, doe, dact;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    int bw = 0;
    int n;

    arpcc_link_if link_i ();
    arpcc_dev u_arpcc_dev (.CLK_IN(clk), .RSTN_IN(rst_n), .CE_IN(1'b1), .LINK(link_i.dev),
        .IMPULSE_MODE_IN(imp), .BANDGAP_EN_OUT(bg), .REFBUF_EN_OUT(rb),
        .BUF_FROM_PIN_OUT(bfp), .TEMP_EN_OUT(temp), .LOW_CURRENT_OUT(lowc),
        .SLEEP_OUT(slp), .BUSY_OUT(bsy), .DATA_OE_OUT(doe), .DIGITAL_ACTIVE_OUT(dact));
    arpcc_hst u_arpcc_hst (.CLK_IN(clk), .RSTN_IN(rst_n), .CE_IN(1'b1), .LINK(link_i.hst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    arpcc_monitor u_arpcc_monitor (.CLK_IN(clk), .RSTN_IN(rst_n),
        .sleep_request(link_i.sleep_request), .convert_start_n(link_i.convert_start_n),
        .cs_n(link_i.cs_n), .rd_n(link_i.rd_n), .cfg_sleep_ctrl(link_i.cfg_sleep_ctrl),
        .cfg_sleep(link_i.cfg_sleep), .busy(link_i.busy));

    always #2 clk = ~clk;
    always @(negedge clk)
    begin
        if (bsy === 1'b1)
            bw++;
    end
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            miscompares++;
            final_report();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task wait_busy(input logic lv);
        n = 0;
        while (bsy !== lv && n < 400)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_busy

    task t_reset;
        cyc(2);
        `CHK("cs_n", 1'b1, link_i.cs_n)
        `CHK("data_oe_off", 1'b0, doe)
        `CHK("start_n", 1'b1, link_i.convert_start_n)
        `CHK("active", 1'b1, dact)
        apb(1'b0, OFS_CTRL, 32'h00000000);
        `CHK("ctrl", 32'h00000060, rd)
        apb(1'b0, 12'h00C, 32'h00000000);
        `CHK("slverr", 1'b1, er)
        `CHK("unmapped", 32'h00000000, rd)
        $display("test reset done");
    endtask : t_reset

    task t_refs;
        logic [3:0] exp [4];
        exp = '{4'hD, 4'h6, 4'h8, 4'h0};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, OFS_CTRL, 32'h00000060 | 32'(i));
            cyc(6);
            `CHK("refs", exp[i], {bg, rb, bfp, temp})
        end
        $display("test refs done");
    endtask : t_refs

    task t_conv;
        @(posedge clk);
        imp <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h00000000);
        apb(1'b1, OFS_CMD, 32'h00000001);
        bw = 0;
        wait_busy(1'b1);
        `CHK("lowc_conv", 1'b0, lowc)
        cyc(10);
        apb(1'b1, OFS_CMD, 32'h00000001);
        wait_busy(1'b0);
        `CHK("busy_len", CONV_CYC, bw)
        `CHK("lowc_acq", 1'b1, lowc)
        `CHK("active", 1'b1, dact)
        `CHK("data_oe", 1'b1, doe)
        cyc(20);
        `CHK("no_restart", 1'b0, bsy)
        $display("test conv done");
    endtask : t_conv

    task t_sleep;
        apb(1'b1, OFS_CMD, 32'h00000001);
        wait_busy(1'b1);
        `CHK("lowc_restart", 1'b0, lowc)
        apb(1'b1, OFS_CTRL, 32'h00000004);
        cyc(6);
        `CHK("sleep_defer", 1'b0, slp)
        `CHK("busy_kept", 1'b1, bsy)
        wait_busy(1'b0);
        cyc(2);
        `CHK("sleep", 1'b1, slp)
        `CHK("bandgap", 1'b0, bg)
        apb(1'b0, OFS_STATUS, 32'h00000000);
        `CHK("status", 32'h00000000, rd)
        apb(1'b1, OFS_CMD, 32'h00000001);
        cyc(15);
        `CHK("asleep_start", 1'b0, bsy)
        @(posedge clk);
        imp <= 1'b0;
        cyc(2);
        `CHK("lowc_off", 1'b0, lowc)
        apb(1'b1, OFS_CTRL, 32'h00000000);
        cyc(6);
        `CHK("wake", 1'b0, slp)
        $display("test sleep done");
    endtask : t_sleep

    task t_cfg;
        apb(1'b1, OFS_CTRL, 32'h00000018);
        cyc(6);
        `CHK("cfg_sleep", 1'b1, slp)
        apb(1'b1, OFS_CTRL, 32'h00000000);
        apb(1'b1, OFS_CTRL, 32'h00000004);
        apb(1'b1, OFS_CTRL, 32'h0000000C);
        cyc(6);
        `CHK("pin_held", 1'b1, link_i.sleep_request)
        `CHK("pin_ignored", 1'b0, slp)
        apb(1'b1, OFS_CTRL, 32'h00000000);
        apb(1'b1, OFS_CTRL, 32'h00000000);
        $display("test cfg done");
    endtask : t_cfg

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_refs();
        t_conv();
        t_sleep();
        t_cfg();
        final_report();
    end
endmodule : arpcc_test
